// file: rtl/csx_pkg.sv
// package for the stack/logic/round execution slice
// assumes a single processor clock domain and a 32-bit word data memory
package csx_pkg;
	localparam int WORD_W = 32;
	localparam int EXT_W = 40;
	localparam int ADDR_W = 24;
	localparam int REG_IDX_W = 5;
	localparam int EXT_IDX_W = 3;
	localparam int NUM_EXT_REGS = 8;
	localparam logic [ADDR_W-1:0] STACK_PTR_RESET = 24'h000000;
	localparam logic [ADDR_W-1:0] PC_RESET = 24'h000000;
	localparam int STATUS_IRQ_EN_BIT = 13;
	// extended format: exponent [39:32], sign [31], fraction [30:0]
	localparam int EXP_MSB = 39;
	localparam int EXP_LSB = 32;
	localparam int MANT_MSB = 31;
	// single precision keeps the top 24 bits of the signed mantissa
	localparam int ROUND_CUT = 8;
	localparam logic [7:0] EXP_MAX = 8'h7f;

	typedef enum logic [3:0] {
		CSX_OP_NONE = 4'h0,
		CSX_OP_OR2 = 4'h1,
		CSX_OP_OR_THREE = 4'h2,
		CSX_OP_POP = 4'h3,
		CSX_OP_POP_FLOAT = 4'h4,
		CSX_OP_PUSH = 4'h5,
		CSX_OP_PUSH_FLOAT = 4'h6,
		CSX_OP_RET_IRQ = 4'h7,
		CSX_OP_RET_SUB = 4'h8,
		CSX_OP_ROUND = 4'h9
	} csx_op_t;

	typedef struct packed {
		csx_op_t op;
		logic [REG_IDX_W-1:0] dst;
		logic [EXT_W-1:0] first_source_operand;
		logic [EXT_W-1:0] second_source_operand;
		logic has_cond;
		logic cond_true;
	} csx_instr_t;

	typedef struct packed {
		logic wr;
		logic is_float;
		logic [REG_IDX_W-1:0] idx;
		logic [EXT_W-1:0] data;
	} csx_regwr_t;

	typedef struct packed {
		logic req;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} csx_mem_t;
endpackage : csx_pkg

// file: rtl/csx_round.sv
// round of an extended-precision value to single precision
// assumes operands in the extended format of csx_pkg
`timescale 1ns/1ps
`default_nettype none
module csx_round (
	input wire logic [csx_pkg::EXT_W-1:0] value_in,
	output logic [csx_pkg::EXT_W-1:0] value_out
);
	wire [7:0] exp_in = value_in[csx_pkg::EXP_MSB:csx_pkg::EXP_LSB];
	wire [31:0] mant_in = value_in[csx_pkg::MANT_MSB:0];
	wire [32:0] mant_sum = {mant_in[31], mant_in} + 33'h000000080;
	// overflow of the positive mantissa renormalises by one exponent step
	wire mant_ovf = ~mant_in[31] & mant_sum[31];
	wire exp_sat = mant_ovf & (exp_in == csx_pkg::EXP_MAX);
	wire [7:0] exp_out = mant_ovf ? exp_in + 8'h01 : exp_in;
	wire [31:0] mant_shift = {1'b0, mant_sum[31:1]};
	wire [31:0] mant_pick = mant_ovf ? mant_shift : mant_sum[31:0];
	wire [31:0] mant_out = exp_sat ? 32'h7fffff00 : {mant_pick[31:csx_pkg::ROUND_CUT], 8'h00};
	assign value_out = {exp_sat ? csx_pkg::EXP_MAX : exp_out, mant_out};
endmodule : csx_round
`default_nettype wire

// file: rtl/csx_exec.sv
// execution unit for or, push/pop, returns and round
// assumes a data memory that answers a read with mem_rvalid one or more cycles later
// Functional notes
// - two-operand or merges destination and source, result to destination
// - three-operand or merges both sources into destination, sources untouched
// - integer pop reads word at stack pointer into destination register
// - floating pop loads top-of-stack word into an extended register as float
// - integer push increments stack pointer then stores source register
// - floating push increments stack pointer then stores extended register
// - taken interrupt return loads pc from stack and sets interrupt enable
// - taken subroutine return loads pc from stack, else next instruction
// - round source to nearest single precision into extended register
// - extended register operands limited to registers zero through seven
`timescale 1ns/1ps
`default_nettype none
module csx_exec (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire csx_pkg::csx_instr_t instr,
	output logic instr_ready,
	output csx_pkg::csx_regwr_t reg_wr,
	output csx_pkg::csx_mem_t mem,
	input wire logic mem_rvalid,
	input wire logic [csx_pkg::WORD_W-1:0] mem_rdata,
	output logic [csx_pkg::ADDR_W-1:0] stack_pointer,
	output logic [csx_pkg::ADDR_W-1:0] pc,
	output logic pc_load,
	output logic global_irq_enable_bit,
	output logic illegal_reg
);
	// ****************************************
	// decode
	// ****************************************
	typedef enum logic [1:0] {
		CSX_IDLE = 2'b00,
		CSX_READ = 2'b01
	} csx_state_t;

	csx_state_t state;
	csx_pkg::csx_op_t pend_op;
	logic [csx_pkg::REG_IDX_W-1:0] pend_dst;

	function automatic logic ext_ok(input logic [csx_pkg::REG_IDX_W-1:0] idx);
		ext_ok = idx < csx_pkg::REG_IDX_W'(csx_pkg::NUM_EXT_REGS);
	endfunction : ext_ok

	wire csx_pkg::csx_op_t op = instr.op;
	wire is_ext_op = (op == csx_pkg::CSX_OP_POP_FLOAT) || (op == csx_pkg::CSX_OP_PUSH_FLOAT) ||
		(op == csx_pkg::CSX_OP_ROUND);
	wire bad_ext = is_ext_op & ~ext_ok(instr.dst);
	wire taken = ~instr.has_cond | instr.cond_true;
	wire is_ret = (op == csx_pkg::CSX_OP_RET_IRQ) || (op == csx_pkg::CSX_OP_RET_SUB);
	wire is_pop = (op == csx_pkg::CSX_OP_POP) || (op == csx_pkg::CSX_OP_POP_FLOAT);
	wire is_push = (op == csx_pkg::CSX_OP_PUSH) || (op == csx_pkg::CSX_OP_PUSH_FLOAT);
	wire fire = instr_valid && state == CSX_IDLE;
	wire start_read = fire & ~bad_ext & (is_pop | (is_ret & taken));
	wire do_push = fire & ~bad_ext & is_push;
	wire done_read = state == CSX_READ && mem_rvalid;
	wire [csx_pkg::ADDR_W-1:0] stack_ptr_inc = stack_pointer + 24'h000001;
	wire [csx_pkg::ADDR_W-1:0] stack_ptr_dec = stack_pointer - 24'h000001;
	wire [csx_pkg::EXT_W-1:0] rounded_val;
	wire [csx_pkg::EXT_W-1:0] or2_val = instr.second_source_operand | instr.first_source_operand;
	wire [csx_pkg::EXT_W-1:0] or3_val = instr.first_source_operand | instr.second_source_operand;

	assign instr_ready = state == CSX_IDLE;

	csx_round u_round (
		.value_in(instr.first_source_operand),
		.value_out(rounded_val)
	);

	// ****************************************
	// register write-back selection
	// ****************************************
	csx_pkg::csx_regwr_t next_reg_wr;
	always_comb begin
		next_reg_wr = '0;
		if (done_read && (pend_op == csx_pkg::CSX_OP_POP)) begin
			next_reg_wr.wr = 1'b1;
			next_reg_wr.idx = pend_dst;
			next_reg_wr.data = {8'h00, mem_rdata};
		end else if (done_read && (pend_op == csx_pkg::CSX_OP_POP_FLOAT)) begin
			next_reg_wr.wr = 1'b1;
			next_reg_wr.is_float = 1'b1;
			next_reg_wr.idx = pend_dst;
			// stack word holds exponent in the top byte, mantissa low bits cleared
			next_reg_wr.data = {mem_rdata[31:24], mem_rdata[23:0], 8'h00};
		end else if (fire && op == csx_pkg::CSX_OP_OR2) begin
			next_reg_wr.wr = 1'b1;
			next_reg_wr.idx = instr.dst;
			next_reg_wr.data = {8'h00, or2_val[31:0]};
		end else if (fire && op == csx_pkg::CSX_OP_OR_THREE) begin
			next_reg_wr.wr = 1'b1;
			next_reg_wr.idx = instr.dst;
			next_reg_wr.data = {8'h00, or3_val[31:0]};
		end else if (fire && op == csx_pkg::CSX_OP_ROUND && !bad_ext) begin
			next_reg_wr.wr = 1'b1;
			next_reg_wr.is_float = 1'b1;
			next_reg_wr.idx = instr.dst;
			next_reg_wr.data = rounded_val;
		end
	end

	// ****************************************
	// memory request
	// ****************************************
	csx_pkg::csx_mem_t next_mem;
	always_comb begin
		next_mem = '0;
		if (do_push) begin
			next_mem.req = 1'b1;
			next_mem.wr = 1'b1;
			next_mem.addr = stack_ptr_inc;
			// floating push keeps exponent and upper mantissa only
			next_mem.wdata = (op == csx_pkg::CSX_OP_PUSH_FLOAT) ?
				{instr.first_source_operand[39:32], instr.first_source_operand[31:8]} :
				instr.first_source_operand[31:0];
		end else if (start_read) begin
			next_mem.req = 1'b1;
			next_mem.addr = stack_pointer;
		end
	end

	// ****************************************
	// state
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CSX_IDLE;
			pend_op <= csx_pkg::CSX_OP_NONE;
			pend_dst <= '0;
		end else if (start_read) begin
			state <= CSX_READ;
			pend_op <= op;
			pend_dst <= instr.dst;
		end else if (done_read) begin
			state <= CSX_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stack_pointer <= csx_pkg::STACK_PTR_RESET;
		end else if (do_push) begin
			stack_pointer <= stack_ptr_inc;
		end else if (done_read) begin
			stack_pointer <= stack_ptr_dec;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr <= '0;
			mem <= '0;
			illegal_reg <= 1'b0;
		end else begin
			reg_wr <= next_reg_wr;
			mem <= next_mem;
			illegal_reg <= fire & bad_ext;
		end
	end

	// ****************************************
	// return handling
	// ****************************************
	wire ret_done = done_read && (pend_op == csx_pkg::CSX_OP_RET_IRQ || pend_op == csx_pkg::CSX_OP_RET_SUB);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= csx_pkg::PC_RESET;
			pc_load <= 1'b0;
			global_irq_enable_bit <= 1'b0;
		end else begin
			pc_load <= ret_done;
			if (ret_done) begin
				pc <= mem_rdata[csx_pkg::ADDR_W-1:0];
			end
			if (done_read && pend_op == csx_pkg::CSX_OP_RET_IRQ) begin
				global_irq_enable_bit <= 1'b1;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_push_fire;
		fire && is_push && !bad_ext;
	endsequence
	sequence s_pop_done;
		done_read && (pend_op == csx_pkg::CSX_OP_POP || pend_op == csx_pkg::CSX_OP_POP_FLOAT);
	endsequence

	a_or2_result: assert property (@(posedge mclk) disable iff (!rst_n)
		fire && op == csx_pkg::CSX_OP_OR2 |=> reg_wr.wr && reg_wr.data[31:0] ==
		($past(instr.first_source_operand[31:0]) | $past(instr.second_source_operand[31:0])))
		else $error("or2 result wrong");
	a_or_three_result: assert property (@(posedge mclk) disable iff (!rst_n)
		fire && op == csx_pkg::CSX_OP_OR_THREE |=> reg_wr.wr && reg_wr.idx == $past(instr.dst) &&
		reg_wr.data[31:0] == ($past(instr.first_source_operand[31:0]) | $past(instr.second_source_operand[31:0])))
		else $error("three-operand or write wrong");
	a_pop_int_load: assert property (@(posedge mclk) disable iff (!rst_n)
		done_read && pend_op == csx_pkg::CSX_OP_POP |=> reg_wr.wr && !reg_wr.is_float &&
		reg_wr.data[31:0] == $past(mem_rdata))
		else $error("pop data not written");
	a_pop_float_load: assert property (@(posedge mclk) disable iff (!rst_n)
		done_read && pend_op == csx_pkg::CSX_OP_POP_FLOAT |=> reg_wr.wr && reg_wr.is_float)
		else $error("floating pop not float write");
	a_push_preinc: assert property (@(posedge mclk) disable iff (!rst_n)
		s_push_fire |=> mem.wr && mem.addr == stack_pointer && stack_pointer == $past(stack_pointer) + 24'h000001)
		else $error("push address not preincremented");
	a_irq_ret_enable: assert property (@(posedge mclk) disable iff (!rst_n)
		done_read && pend_op == csx_pkg::CSX_OP_RET_IRQ |=> pc_load && global_irq_enable_bit)
		else $error("interrupt return did not set enable");
	a_untaken_ret_skip: assert property (@(posedge mclk) disable iff (!rst_n)
		fire && is_ret && !taken |=> state == CSX_IDLE ##1 !pc_load)
		else $error("untaken return loaded pc");
	a_ext_range: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr.wr && reg_wr.is_float |-> reg_wr.idx < 5'h08)
		else $error("extended register out of range");
	a_pop_decrement: assert property (@(posedge mclk) disable iff (!rst_n)
		s_pop_done |=> stack_pointer == $past(stack_pointer) - 24'h000001)
		else $error("pop did not decrement");
endmodule : csx_exec
`default_nettype wire

// file: verif/csx_stack_mem.sv
// data memory model that holds the system stack
// assumes the csx_exec memory port: one-cycle req pulse, reads answered by a rvalid pulse
`timescale 1ns/1ps
`default_nettype none
module csx_stack_mem (
	input wire logic mclk,
	input wire logic rst_n,
	input wire csx_pkg::csx_mem_t mem,
	input wire logic slow,
	output logic mem_rvalid,
	output logic [csx_pkg::WORD_W-1:0] mem_rdata
);
	logic [csx_pkg::WORD_W-1:0] store [0:255];
	logic pend;
	logic [1:0] cnt;
	logic [7:0] raddr;
	// only the low address byte is decoded; the stack stays shallow here
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			cnt <= 2'h0;
			raddr <= 8'h00;
			mem_rvalid <= 1'b0;
			mem_rdata <= 32'h00000000;
		end else begin
			mem_rvalid <= 1'b0;
			// idle data toggles so a stale word never passes for an answer
			mem_rdata <= ~mem_rdata;
			if (mem.req && mem.wr) begin
				store[mem.addr[7:0]] <= mem.wdata;
			end
			if (mem.req && !mem.wr && !slow) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= store[mem.addr[7:0]];
			end else if (mem.req && !mem.wr) begin
				pend <= 1'b1;
				cnt <= 2'h2;
				raddr <= mem.addr[7:0];
			end else if (pend && cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end else if (pend) begin
				pend <= 1'b0;
				mem_rvalid <= 1'b1;
				mem_rdata <= store[raddr];
			end
		end
	end
endmodule : csx_stack_mem
`default_nettype wire

// file: verif/cpu_stack_logic_round_exec_tb_top.sv
// self-checking bench for the execution slice
// assumes csx_exec and the csx_stack_mem model; stack words land in the model
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_logic_round_exec_tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic slow = 1'b0;
	csx_pkg::csx_instr_t instr = '0;
	csx_pkg::csx_regwr_t reg_wr;
	csx_pkg::csx_mem_t mem;
	logic instr_ready, mem_rvalid, pc_load, global_irq_enable_bit, illegal_reg;
	logic [31:0] mem_rdata;
	logic [23:0] stack_pointer, pc;
	int err_total = 0;
	int total_checks = 0;

	csx_exec uut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .reg_wr(reg_wr), .mem(mem), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .stack_pointer(stack_pointer), .pc(pc), .pc_load(pc_load),
		.global_irq_enable_bit(global_irq_enable_bit), .illegal_reg(illegal_reg));
	csx_stack_mem stack_mem (.mclk(mclk), .rst_n(rst_n), .mem(mem), .slow(slow),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

	always #4 mclk = ~mclk;

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// offers one instruction; returns just after the edge that takes it
	task automatic exe(input csx_pkg::csx_op_t op, input logic [4:0] d, input logic [39:0] a,
		input logic [39:0] b, input logic hc, input logic ct);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr <= '{op: op, dst: d, first_source_operand: a, second_source_operand: b, has_cond: hc, cond_true: ct};
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask : exe

	task automatic wait_done();
		int n;
		n = 0;
		while (reg_wr.wr !== 1'b1 && pc_load !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : wait_done

	// ****************
	// scenarios
	// ****************
	task automatic t_or();
		exe(csx_pkg::CSX_OP_OR2, 5'h03, 40'h00f0f0a5a5, 40'h000f0f5a00, 1'b0, 1'b0);
		chk({reg_wr.wr, reg_wr.idx, reg_wr.data[31:0]}, {1'b1, 5'h03, 32'hffffffa5});
		exe(csx_pkg::CSX_OP_OR_THREE, 5'h11, 40'h0012340000, 40'h0000005678, 1'b0, 1'b0);
		chk({reg_wr.wr, reg_wr.idx, reg_wr.data[31:0]}, {1'b1, 5'h11, 32'h12345678});
	endtask : t_or

	task automatic t_push_pop();
		exe(csx_pkg::CSX_OP_PUSH, 5'h00, 40'h00cafe0001, 40'h0, 1'b0, 1'b0);
		chk({mem.req, mem.wr, mem.addr, mem.wdata, stack_pointer}, {2'b11, 24'h1, 32'hcafe0001, 24'h1});
		exe(csx_pkg::CSX_OP_PUSH_FLOAT, 5'h02, 40'h8140000000, 40'h0, 1'b0, 1'b0);
		chk({mem.req, mem.wr, mem.addr, mem.wdata, stack_pointer}, {2'b11, 24'h2, 32'h81400000, 24'h2});
		slow = 1'b1;
		exe(csx_pkg::CSX_OP_POP_FLOAT, 5'h04, 40'h0, 40'h0, 1'b0, 1'b0);
		chk({mem.req, mem.wr, mem.addr, instr_ready}, {2'b10, 24'h2, 1'b0});
		wait_done();
		chk({reg_wr.is_float, reg_wr.idx, reg_wr.data}, {1'b1, 5'h04, 40'h8140000000});
		chk(stack_pointer, 24'h1);
		slow = 1'b0;
		exe(csx_pkg::CSX_OP_POP, 5'h12, 40'h0, 40'h0, 1'b0, 1'b0);
		chk({mem.req, mem.wr, mem.addr}, {2'b10, 24'h1});
		wait_done();
		chk({reg_wr.is_float, reg_wr.idx, reg_wr.data[31:0]}, {1'b0, 5'h12, 32'hcafe0001});
		chk(stack_pointer, 24'h0);
	endtask : t_push_pop

	task automatic t_returns();
		exe(csx_pkg::CSX_OP_RET_SUB, 5'h00, 40'h0, 40'h0, 1'b1, 1'b0);
		chk({mem.req, pc_load, pc, stack_pointer, instr_ready}, {2'b00, 24'h0, 24'h0, 1'b1});
		exe(csx_pkg::CSX_OP_PUSH, 5'h00, 40'h0000000123, 40'h0, 1'b0, 1'b0);
		exe(csx_pkg::CSX_OP_RET_SUB, 5'h00, 40'h0, 40'h0, 1'b1, 1'b1);
		wait_done();
		chk({pc_load, pc, stack_pointer, global_irq_enable_bit}, {1'b1, 24'h123, 24'h0, 1'b0});
		exe(csx_pkg::CSX_OP_RET_IRQ, 5'h00, 40'h0, 40'h0, 1'b1, 1'b0);
		chk({mem.req, pc_load, global_irq_enable_bit, instr_ready}, 4'b0001);
		exe(csx_pkg::CSX_OP_PUSH, 5'h00, 40'h0000000456, 40'h0, 1'b0, 1'b0);
		slow = 1'b1;
		exe(csx_pkg::CSX_OP_RET_IRQ, 5'h00, 40'h0, 40'h0, 1'b0, 1'b0);
		wait_done();
		chk({pc_load, pc, stack_pointer, global_irq_enable_bit}, {1'b1, 24'h456, 24'h0, 1'b1});
		slow = 1'b0;
	endtask : t_returns

	task automatic t_round();
		logic [39:0] rin [2] = '{40'h0500000080, 40'h051234567f};
		logic [39:0] rexp [2] = '{40'h0500000100, 40'h0512345600};
		for (int i = 0; i < 2; i++) begin
			exe(csx_pkg::CSX_OP_ROUND, 5'h06, rin[i], 40'h0, 1'b0, 1'b0);
			chk({reg_wr.wr, reg_wr.is_float, reg_wr.idx, reg_wr.data}, {2'b11, 5'h06, rexp[i]});
		end
		exe(csx_pkg::CSX_OP_ROUND, 5'h09, rin[0], 40'h0, 1'b0, 1'b0);
		chk({illegal_reg, reg_wr.wr}, 2'b10);
		exe(csx_pkg::CSX_OP_POP_FLOAT, 5'h08, 40'h0, 40'h0, 1'b0, 1'b0);
		chk({illegal_reg, mem.req, stack_pointer}, {2'b10, 24'h0});
	endtask : t_round

	// mid-run reset: only reset may clear the enable bit
	task automatic t_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk({instr_ready, stack_pointer, pc, global_irq_enable_bit, pc_load}, {1'b1, 24'h0, 24'h0, 2'b00});
		@(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk({instr_ready, stack_pointer, pc, global_irq_enable_bit, mem.req}, {1'b1, 24'h0, 24'h0, 2'b00});
	endtask : t_reset

	task automatic end_of_test();
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk({instr_ready, stack_pointer, pc, global_irq_enable_bit}, {1'b1, 24'h0, 24'h0, 1'b0});
		t_or();
		t_push_pop();
		t_returns();
		t_reset();
		t_round();
		end_of_test();
	end

	// the whole sequence needs well under 300 cycles
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		end_of_test();
	end
endmodule : cpu_stack_logic_round_exec_tb_top
`default_nettype wire
